// File: cicr_defs.vh
/*
  Shared constants of the codec indexed control register bank: index
  addresses, control word fields, register field positions, reset values
  and the sample rate divide factors.
  Assumes it is included by its bare name from the design file.
*/
`ifndef CICR_DEFS_VH
`define CICR_DEFS_VH

// Index addresses.
`define CICR_IDX_DATA_FORMAT   4'h8
`define CICR_IDX_IFC_CONFIG    4'h9
`define CICR_IDX_PIN_CONTROL   4'ha
`define CICR_IDX_INVALID_11    4'hb
`define CICR_IDX_MISC_INFO     4'hc
`define CICR_IDX_DIG_MIX       4'hd
`define CICR_IDX_INVALID_14    4'he
`define CICR_IDX_INVALID_15    4'hf

// Control word fields.
`define CICR_CW_MCE            14
`define CICR_CW_READ_REQ       13
`define CICR_CW_IDX_HI         11
`define CICR_CW_IDX_LO         8

// Data format register fields.
`define CICR_DF_CLK_SRC        0
`define CICR_DF_DIV_LO         1
`define CICR_DF_DIV_HI         3
`define CICR_DF_STEREO         4
`define CICR_DF_COMPANDED      5
`define CICR_DF_FORMAT         6
`define CICR_DF_MASK           8'h7f

// Interface configuration fields.
`define CICR_IC_PLAY_EN        0
`define CICR_IC_AUTOCAL        3

// Pin control fields.
`define CICR_PC_CLK_TS         5
`define CICR_PC_XCTL_LO        6
`define CICR_PC_XCTL_HI        7
`define CICR_PC_MASK           8'he0

// Miscellaneous register fields.
`define CICR_MI_TX_SLOT        6
`define CICR_MI_FRAME_SIZE     7
`define CICR_MI_MASK           8'hc0

// Digital mix fields.
`define CICR_DM_ENABLE         0
`define CICR_DM_ATT_LO         2
`define CICR_DM_ATT_HI         7
`define CICR_DM_MASK           8'hfd

// Reset values.
`define CICR_RST_DATA_FORMAT   8'h00
`define CICR_RST_IFC_CONFIG    8'h08
`define CICR_RST_PIN_CONTROL   8'h00
`define CICR_RST_MISC_INFO     8'h00
`define CICR_RST_DIG_MIX       8'h00

// Sample rate divide factors by divider code.
`define CICR_DIV_0             12'hc00
`define CICR_DIV_1             12'h600
`define CICR_DIV_2             12'h380
`define CICR_DIV_3             12'h300
`define CICR_DIV_4             12'h1c0
`define CICR_DIV_5             12'h180
`define CICR_DIV_6             12'h200
`define CICR_DIV_7             12'ha00

// Transmit slot bases.
`define CICR_SLOT_BASE_2WIRE   5'h00
`define CICR_SLOT_BASE_1WIRE   5'h03

// Gain of the fine 1.5 dB attenuation steps, unsigned Q8.
`define CICR_ATT_STEP0         9'h100
`define CICR_ATT_STEP1         9'h0d7
`define CICR_ATT_STEP2         9'h0b5
`define CICR_ATT_STEP3         9'h099

`endif

// File: cicr_regs.v
/*
  Indexed control register bank of the stereo codec, indices 8 to 15,
  with the sample rate divider, pin control and digital loopback mix.
  Assumes the serial framing logic on clk_i delivers each received
  control word as a one-cycle strobe and marks frame sync and sample
  data with one-cycle strobes; crystal and bus master pins are
  asynchronous.

// Summary of operation
// - Clock source bit 1 takes the sample rate from the second crystal.
// - Clock source bit 0 takes the sample rate from the first crystal.
// - Divider code 0-7 selects 3072,1536,896,768,448,384,512,2560.
// - An external clock on a crystal input is divided the same way.
// - Channel bit picks mono or stereo; mono duplicates playback, captures left.
// - Companding and format bits pick linear or companded sample formats.
// - Data format writes are dropped outside the mode change state.
// - Mode change state follows its bit in each received control word.
// - Playback enable steers playback and is writable at any time.
// - Leaving mode change runs autocalibration only when autocal is set.
// - The autocal bit changes only inside the mode change state.
// - Interface configuration resets to 08h, autocal set.
// - Clock output drives only when bus master high and tri-state bit low.
// - Two external control pins follow their register bits.
// - Indices 11, 14, 15 ignore writes and read back the status word.
// - Misc register changes only in mode change, applied at frame sync.
// - In 32-slot frames a change waits for the next frame's first sample.
// - Transmit uses slots 3-5 for one wire, slots 0-2 for two wires.
// - Transmit slot bit 1 selects slots 0-2, bit 0 selects slots 3-5.
// - Frame size bit 0 gives 32 slots per frame, 1 gives 16.
// - Mix enable adds attenuated ADC data to DAC data; otherwise muted.
// - On capture overrun the last good capture sample feeds the mix.
// - On playback underrun with playback enabled, midscale zero is mixed.
// - Six-bit mix attenuation steps 1.5 dB from 0 to 94.5 dB.
// - Data format, pin, misc and mix registers reset to zero.
*/
`timescale 1ns/1ps
`include "cicr_defs.vh"

module cicr_regs (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rstn_i,
  // Control word path from the serial framing
  input  wire        ctl_valid_i,
  input  wire [15:0] ctl_word_i,
  input  wire [15:0] status_word_i,
  input  wire [7:0]  analog_rdata_i,
  input  wire        frame_sync_i,
  // Asynchronous pins
  input  wire        first_crystal_input_i,
  input  wire        second_crystal_input_i,
  input  wire        bus_master_input_i,
  // Readback and slot control
  output reg         readback_valid_o,
  output reg  [15:0] readback_word_o,
  output reg         frame_size_select_o,
  output reg         transmit_slot_select_o,
  output reg  [4:0]  tx_slot_base_o,
  // Mode and calibration
  output reg         mode_change_enable_o,
  output reg         autocal_start_o,
  // Sample format and rate
  output reg         sample_tick_o,
  output wire        clock_source_select_o,
  output wire [2:0]  rate_divider_select_o,
  output wire        stereo_o,
  output wire        companded_o,
  output wire        sample_format_select_o,
  output wire        playback_enable_o,
  // Pins
  output wire [1:0]  external_control_outputs_o,
  output reg         clock_output_pin_o,
  output reg         clock_output_pin_oe_o,
  // Digital mix data path
  input  wire        play_valid_i,
  input  wire [15:0] play_left_i,
  input  wire [15:0] play_right_i,
  input  wire        playback_underrun_i,
  input  wire        adc_valid_i,
  input  wire [15:0] adc_left_i,
  input  wire [15:0] adc_right_i,
  input  wire        capture_overrun_i,
  output reg  [15:0] dac_left_o,
  output reg  [15:0] dac_right_o
);

  localparam NPIN = 3;

  reg  [7:0]      data_format_q;
  reg  [7:0]      ifc_config_q;
  reg  [7:0]      pin_control_q;
  reg  [7:0]      misc_info_q;
  reg  [7:0]      dig_mix_q;
  reg  [11:0]     div_cnt_q;
  reg  [NPIN-1:0] flt_q;
  reg             xtal_prev_q;
  reg  [15:0]     play_l_q;
  reg  [15:0]     play_r_q;
  reg  [15:0]     adc_l_q;
  reg  [15:0]     adc_r_q;

  wire [NPIN-1:0] pin_raw;
  wire [NPIN-1:0] pin_s2;
  wire [NPIN-1:0] pin_s3;
  wire [3:0]      cw_idx;
  wire            cw_mce;
  wire            cw_write;
  wire            xtal_sel;
  wire            xtal_rise;
  wire [11:0]     div_factor;
  wire [15:0]     mix_l;
  wire [15:0]     mix_r;
  wire [15:0]     play_l_src;
  wire [15:0]     play_r_src;
  wire [15:0]     adc_r_src;

  // Index decode, used for both write and readback selection.
  function is_invalid_index;
    input [3:0] idx;
    begin
      is_invalid_index = (idx == `CICR_IDX_INVALID_11) ||
                         (idx == `CICR_IDX_INVALID_14) ||
                         (idx == `CICR_IDX_INVALID_15);
    end
  endfunction

  function [11:0] divide_of;
    input [2:0] code;
    begin
      case (code)
        3'h0:    divide_of = `CICR_DIV_0;
        3'h1:    divide_of = `CICR_DIV_1;
        3'h2:    divide_of = `CICR_DIV_2;
        3'h3:    divide_of = `CICR_DIV_3;
        3'h4:    divide_of = `CICR_DIV_4;
        3'h5:    divide_of = `CICR_DIV_5;
        3'h6:    divide_of = `CICR_DIV_6;
        default: divide_of = `CICR_DIV_7;
      endcase
    end
  endfunction

  // Every four steps is an exact 6 dB shift; the fine steps scale in Q8.
  function [15:0] attenuate;
    input [15:0] x;
    input [5:0]  a;
    reg   [8:0]         m;
    reg   signed [25:0] p;
    begin
      case (a[1:0])
        2'h0:    m = `CICR_ATT_STEP0;
        2'h1:    m = `CICR_ATT_STEP1;
        2'h2:    m = `CICR_ATT_STEP2;
        default: m = `CICR_ATT_STEP3;
      endcase
      p = $signed(x) * $signed({1'b0, m});
      p = p >>> 8;
      p = p >>> a[5:2];
      attenuate = p[15:0];
    end
  endfunction

  // Clipping keeps a loud loopback from wrapping into the opposite sign.
  function [15:0] sat_add;
    input [15:0] a;
    input [15:0] b;
    reg   [16:0] s;
    begin
      s = {a[15], a} + {b[15], b};
      if (s[16] != s[15]) begin
        sat_add = s[16] ? 16'h8000 : 16'h7fff;
      end else begin
        sat_add = s[15:0];
      end
    end
  endfunction

  assign pin_raw = {bus_master_input_i, second_crystal_input_i,
                    first_crystal_input_i};

  // Three-stage synchronisers; a level is accepted once stages two and
  // three agree. A 12.288 MHz crystal is near the limit of what a 50 MHz
  // sampler can resolve, so rates derived from it assume a clean duty cycle.
  genvar g;
  generate
    for (g = 0; g < NPIN; g = g + 1) begin : g_pin_sync
      reg s1_q;
      reg s2_q;
      reg s3_q;
      always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end else begin
          s1_q <= pin_raw[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end
      assign pin_s2[g] = s2_q;
      assign pin_s3[g] = s3_q;
    end
  endgenerate

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flt_q <= {NPIN{1'b0}};
    end else begin
      flt_q <= (pin_s2 & pin_s3) | (flt_q & (pin_s2 ^ pin_s3));
    end
  end

  assign cw_idx   = ctl_word_i[`CICR_CW_IDX_HI:`CICR_CW_IDX_LO];
  assign cw_mce   = ctl_word_i[`CICR_CW_MCE];
  assign cw_write = ctl_valid_i & ~ctl_word_i[`CICR_CW_READ_REQ];

  // Register writes from received control words.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data_format_q <= `CICR_RST_DATA_FORMAT;
      ifc_config_q  <= `CICR_RST_IFC_CONFIG;
      pin_control_q <= `CICR_RST_PIN_CONTROL;
      misc_info_q   <= `CICR_RST_MISC_INFO;
      dig_mix_q     <= `CICR_RST_DIG_MIX;
    end else if (cw_write && !is_invalid_index(cw_idx)) begin
      case (cw_idx)
        `CICR_IDX_DATA_FORMAT: begin
          if (cw_mce) begin
            data_format_q <= ctl_word_i[7:0] & `CICR_DF_MASK;
          end
        end
        `CICR_IDX_IFC_CONFIG: begin
          ifc_config_q[`CICR_IC_PLAY_EN] <= ctl_word_i[`CICR_IC_PLAY_EN];
          if (cw_mce) begin
            ifc_config_q[`CICR_IC_AUTOCAL] <= ctl_word_i[`CICR_IC_AUTOCAL];
          end
        end
        `CICR_IDX_PIN_CONTROL: begin
          pin_control_q <= ctl_word_i[7:0] & `CICR_PC_MASK;
        end
        `CICR_IDX_MISC_INFO: begin
          if (cw_mce) begin
            misc_info_q <= ctl_word_i[7:0] & `CICR_MI_MASK;
          end
        end
        `CICR_IDX_DIG_MIX: begin
          dig_mix_q <= ctl_word_i[7:0] & `CICR_DM_MASK;
        end
        default: begin
        end
      endcase
    end
  end

  // Mode change state and autocalibration on its exit.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_change_enable_o <= 1'b0;
      autocal_start_o      <= 1'b0;
    end else begin
      autocal_start_o <= 1'b0;
      if (ctl_valid_i) begin
        mode_change_enable_o <= cw_mce;
        if (mode_change_enable_o && !cw_mce) begin
          autocal_start_o <= ifc_config_q[`CICR_IC_AUTOCAL];
        end
      end
    end
  end

  // Index readback, one cycle after each control word.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      readback_valid_o <= 1'b0;
      readback_word_o  <= 16'h0000;
    end else begin
      readback_valid_o <= ctl_valid_i;
      if (ctl_valid_i) begin
        if (is_invalid_index(cw_idx)) begin
          readback_word_o <= status_word_i;
        end else begin
          readback_word_o[15:8] <= ctl_word_i[15:8];
          case (cw_idx)
            `CICR_IDX_DATA_FORMAT: readback_word_o[7:0] <= data_format_q;
            `CICR_IDX_IFC_CONFIG:  readback_word_o[7:0] <= ifc_config_q;
            `CICR_IDX_PIN_CONTROL: readback_word_o[7:0] <= pin_control_q;
            `CICR_IDX_MISC_INFO:   readback_word_o[7:0] <= misc_info_q;
            `CICR_IDX_DIG_MIX:     readback_word_o[7:0] <= dig_mix_q;
            default:               readback_word_o[7:0] <= analog_rdata_i;
          endcase
        end
      end
    end
  end

  // Frame geometry takes effect only on a frame sync. In 32-slot frames
  // the mid-frame sample boundary is not a frame sync, so a change made
  // in the first sample waits for the next frame.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      frame_size_select_o    <= 1'b0;
      transmit_slot_select_o <= 1'b0;
      tx_slot_base_o         <= `CICR_SLOT_BASE_1WIRE;
    end else if (frame_sync_i) begin
      frame_size_select_o    <= misc_info_q[`CICR_MI_FRAME_SIZE];
      transmit_slot_select_o <= misc_info_q[`CICR_MI_TX_SLOT];
      tx_slot_base_o <= misc_info_q[`CICR_MI_TX_SLOT] ?
                        `CICR_SLOT_BASE_2WIRE : `CICR_SLOT_BASE_1WIRE;
    end
  end

  assign clock_source_select_o  = data_format_q[`CICR_DF_CLK_SRC];
  assign rate_divider_select_o  = data_format_q[`CICR_DF_DIV_HI:`CICR_DF_DIV_LO];
  assign stereo_o               = data_format_q[`CICR_DF_STEREO];
  assign companded_o            = data_format_q[`CICR_DF_COMPANDED];
  assign sample_format_select_o = data_format_q[`CICR_DF_FORMAT];
  assign playback_enable_o      = ifc_config_q[`CICR_IC_PLAY_EN];
  assign external_control_outputs_o =
    pin_control_q[`CICR_PC_XCTL_HI:`CICR_PC_XCTL_LO];

  // Whatever clock reaches the selected input is counted, so an external
  // source of up to a quarter of the clk_i frequency yields its own rate.
  assign xtal_sel   = clock_source_select_o ? flt_q[1] : flt_q[0];
  assign xtal_rise  = xtal_sel & ~xtal_prev_q;
  assign div_factor = divide_of(rate_divider_select_o);

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      xtal_prev_q   <= 1'b0;
      div_cnt_q     <= 12'h000;
      sample_tick_o <= 1'b0;
    end else begin
      xtal_prev_q   <= xtal_sel;
      sample_tick_o <= 1'b0;
      if (xtal_rise) begin
        if (div_cnt_q >= div_factor - 12'h001) begin
          div_cnt_q     <= 12'h000;
          sample_tick_o <= 1'b1;
        end else begin
          div_cnt_q <= div_cnt_q + 12'h001;
        end
      end
    end
  end

  // Clock output follows the selected clock while enabled.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clock_output_pin_o    <= 1'b0;
      clock_output_pin_oe_o <= 1'b0;
    end else begin
      clock_output_pin_o    <= xtal_sel;
      clock_output_pin_oe_o <= flt_q[2] & ~pin_control_q[`CICR_PC_CLK_TS];
    end
  end

  // Sample holding for playback and the loopback source.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      play_l_q <= 16'h0000;
      play_r_q <= 16'h0000;
      adc_l_q  <= 16'h0000;
      adc_r_q  <= 16'h0000;
    end else begin
      if (play_valid_i) begin
        play_l_q <= play_left_i;
        play_r_q <= play_right_i;
      end
      if (adc_valid_i && !capture_overrun_i) begin
        adc_l_q <= adc_left_i;
        adc_r_q <= adc_right_i;
      end
    end
  end

  // Mono plays one sample on both channels and loops back only the left.
  assign play_l_src = (playback_enable_o && !playback_underrun_i) ?
                      play_l_q : 16'h0000;
  assign play_r_src = !playback_enable_o || playback_underrun_i ? 16'h0000 :
                      (stereo_o ? play_r_q : play_l_q);
  assign adc_r_src  = stereo_o ? adc_r_q : adc_l_q;
  assign mix_l = dig_mix_q[`CICR_DM_ENABLE] ?
                 attenuate(adc_l_q, dig_mix_q[`CICR_DM_ATT_HI:`CICR_DM_ATT_LO]) :
                 16'h0000;
  assign mix_r = dig_mix_q[`CICR_DM_ENABLE] ?
                 attenuate(adc_r_src, dig_mix_q[`CICR_DM_ATT_HI:`CICR_DM_ATT_LO]) :
                 16'h0000;

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dac_left_o  <= 16'h0000;
      dac_right_o <= 16'h0000;
    end else if (sample_tick_o) begin
      dac_left_o  <= sat_add(play_l_src, mix_l);
      dac_right_o <= sat_add(play_r_src, mix_r);
    end
  end

endmodule // cicr_regs

// File: cicr_regs_props.sv
/*
  Concurrent checks on the ports of the indexed control register bank.
  Assumes it is bound to cicr_regs and sees nothing but its ports.
*/
`timescale 1ns/1ps
module cicr_regs_props (
  // Clock and reset
  input wire        clk_i,
  input wire        rstn_i,
  // Observed ports
  input wire        ctl_valid_i,
  input wire [15:0] ctl_word_i,
  input wire [15:0] status_word_i,
  input wire        frame_sync_i,
  input wire        bus_master_input_i,
  input wire        readback_valid_o,
  input wire [15:0] readback_word_o,
  input wire        frame_size_select_o,
  input wire        transmit_slot_select_o,
  input wire [4:0]  tx_slot_base_o,
  input wire        mode_change_enable_o,
  input wire        autocal_start_o,
  input wire        clock_source_select_o,
  input wire [2:0]  rate_divider_select_o,
  input wire        stereo_o,
  input wire        companded_o,
  input wire        sample_format_select_o,
  input wire        playback_enable_o,
  input wire [1:0]  external_control_outputs_o,
  input wire        clock_output_pin_oe_o
);
  wire [6:0] fmt = {sample_format_select_o, companded_o, stereo_o,
                    rate_divider_select_o, clock_source_select_o};
  wire [3:0] idx = ctl_word_i[11:8];
  wire       wr  = ctl_valid_i && !ctl_word_i[13];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  a_readback_pulse: assert property (readback_valid_o == $past(ctl_valid_i))
    else $error("readback strobe does not follow control word");
  a_status_readback: assert property (ctl_valid_i && (idx == 4'hb || idx >= 4'he)
    |=> readback_word_o == $past(status_word_i)) else $error("invalid index readback");
  a_mce_follows: assert property (ctl_valid_i |=> mode_change_enable_o == $past(ctl_word_i[14]))
    else $error("mode change state not taken from word");
  a_format_locked: assert property (!(wr && idx == 4'h8 && ctl_word_i[14]) |=> $stable(fmt))
    else $error("data format changed outside mode change");
  a_pen_write: assert property (wr && idx == 4'h9 |=> playback_enable_o == $past(ctl_word_i[0]))
    else $error("playback enable not written");
  a_autocal_exit: assert property (autocal_start_o |-> $past(mode_change_enable_o)
    && !mode_change_enable_o) else $error("autocal start without leaving mode change");
  a_xctl_follow: assert property (wr && idx == 4'ha
    |=> external_control_outputs_o == $past(ctl_word_i[7:6])) else $error("control pins wrong");
  a_clock_output_pin_off: assert property ((!bus_master_input_i)[*6] |-> !clock_output_pin_oe_o)
    else $error("clock output driven without bus master");
  a_slot_base: assert property (frame_sync_i |=> tx_slot_base_o ==
    (transmit_slot_select_o ? 5'h00 : 5'h03)) else $error("slot base wrong");
  a_frame_hold: assert property (!frame_sync_i |=>
    $stable({frame_size_select_o, transmit_slot_select_o})) else $error("frame setup moved");
endmodule // cicr_regs_props

bind cicr_regs cicr_regs_props i_props (.clk_i, .rstn_i, .ctl_valid_i, .ctl_word_i,
  .status_word_i, .frame_sync_i, .bus_master_input_i, .readback_valid_o, .readback_word_o,
  .frame_size_select_o, .transmit_slot_select_o, .tx_slot_base_o, .mode_change_enable_o,
  .autocal_start_o, .clock_source_select_o, .rate_divider_select_o, .stereo_o, .companded_o,
  .sample_format_select_o, .playback_enable_o, .external_control_outputs_o,
  .clock_output_pin_oe_o);

// File: cicr_dsp_model.sv
/*
  Controller model that sends control words to the register bank and
  keeps the last readback word. Assumes the bench pulses req_i for one
  cycle per word and leaves four cycles between requests.
*/
`timescale 1ns/1ps
`include "cicr_defs.vh"
module cicr_dsp_model (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rstn_i,
  // Bench side
  input  wire        req_i,
  input  wire [15:0] word_i,
  output reg  [15:0] rb_o,
  // Codec side
  output reg         ctl_valid_o,
  output reg  [15:0] ctl_word_o,
  input  wire        readback_valid_i,
  input  wire [15:0] readback_word_i
);
  reg [7:0] keep;
  always @* begin
    case (word_i[11:8])
      4'h8: keep = `CICR_DF_MASK;
      4'h9: keep = 8'h09;
      4'ha: keep = `CICR_PC_MASK;
      4'hc: keep = `CICR_MI_MASK;
      4'hd: keep = `CICR_DM_MASK;
      default: keep = 8'hff;
    endcase
  end
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctl_valid_o <= 1'b0;
      ctl_word_o  <= 16'h0000;
      rb_o        <= 16'h0000;
    end else begin
      ctl_valid_o <= req_i;
      // Between words the bits are scrambled so nothing leans on a stale word.
      ctl_word_o <= req_i ? {word_i[15:8], word_i[7:0] & keep} : ~ctl_word_o;
      if (readback_valid_i) rb_o <= readback_word_i;
    end
  end
endmodule // cicr_dsp_model

// File: tb_top.sv
/*
  Self-checking bench of the indexed control register bank.
  Assumes the register bank and the controller model are compiled first.
*/
`timescale 1ns/1ps
`include "cicr_defs.vh"
module tb_top;
  reg clk_i = 1'b0, rstn_i = 1'b0, req = 1'b0, pv = 1'b0, av = 1'b0, und = 1'b0;
  reg ovr = 1'b0, fs = 1'b0, x1 = 1'b0, x2 = 1'b0, bm = 1'b0;
  reg [15:0] w = 16'h0000, sw = 16'h5a3c, pl = 16'h0000, pr = 16'h0000;
  reg [15:0] al = 16'h0000, ar = 16'h0000, ea = 16'h0000, eb = 16'h0000;
  reg [7:0] ard = 8'h00;
  reg [7:0] ex [8:15];
  reg [31:0] seed = 32'h0b08351b;
  wire cv, rbv, fss, tss, mode_change_enable, acs, tick, clock_source_select, st, cmp, fmt, playback_enable, ckp, ckoe;
  wire [15:0] cw, rbw, rb, dl, dr;
  wire [4:0] base;
  wire [2:0] div;
  wire [1:0] xo;
  integer mismatches = 0, num_checks = 0, cyc = 0, ncal = 0, nck = 0, i, k, n;
  reg p, d, ckq = 1'b0;
  reg [5:0] at;
  always #10 clk_i = ~clk_i;

  cicr_regs i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .ctl_valid_i(cv), .ctl_word_i(cw),
    .status_word_i(sw), .analog_rdata_i(ard), .frame_sync_i(fs), .first_crystal_input_i(x1),
    .second_crystal_input_i(x2), .bus_master_input_i(bm), .readback_valid_o(rbv),
    .readback_word_o(rbw), .frame_size_select_o(fss), .transmit_slot_select_o(tss),
    .tx_slot_base_o(base), .mode_change_enable_o(mode_change_enable), .autocal_start_o(acs),
    .sample_tick_o(tick), .clock_source_select_o(clock_source_select), .rate_divider_select_o(div),
    .stereo_o(st), .companded_o(cmp), .sample_format_select_o(fmt), .playback_enable_o(playback_enable),
    .external_control_outputs_o(xo), .clock_output_pin_o(ckp), .clock_output_pin_oe_o(ckoe),
    .play_valid_i(pv), .play_left_i(pl), .play_right_i(pr), .playback_underrun_i(und),
    .adc_valid_i(av), .adc_left_i(al), .adc_right_i(ar), .capture_overrun_i(ovr),
    .dac_left_o(dl), .dac_right_o(dr));
  cicr_dsp_model i_dsp (.clk_i(clk_i), .rstn_i(rstn_i), .req_i(req), .word_i(w), .rb_o(rb),
    .ctl_valid_o(cv), .ctl_word_o(cw), .readback_valid_i(rbv), .readback_word_i(rbw));

  function [31:0] rnd(input [31:0] s);
    rnd = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected DAC word: playback term plus attenuated capture term, saturated.
  function [15:0] mixv(input pp, input dd, input [5:0] a, input [15:0] pd, input [15:0] ad);
    reg signed [31:0] m, s;
    reg [8:0] f;
    begin
      case (a[1:0])
        2'd0: f = 9'h100;
        2'd1: f = 9'h0d7;
        2'd2: f = 9'h0b5;
        default: f = 9'h099;
      endcase
      m = ($signed(ad) * $signed({1'b0, f})) >>> 8;
      m = m >>> a[5:2];
      s = (pp ? $signed(pd) : 32'sh0) + (dd ? m : 32'sh0);
      mixv = s > 32'sh7fff ? 16'h7fff : (s < -32'sh8000 ? 16'h8000 : s[15:0]);
    end
  endfunction

  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  task chk(input [8*10:1] nm, input [15:0] e, input [15:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  task cw_send(input [15:0] word);
    begin
      @(posedge clk_i);
      req <= 1'b1;
      w <= word;
      @(posedge clk_i);
      req <= 1'b0;
      repeat (3) @(posedge clk_i);
      #1;
    end
  endtask

  task wr(input [3:0] ix, input [7:0] dt, input m);
    begin
      cw_send({1'b0, m, 2'b00, ix, dt});
      case (ix)
        4'h8: if (m) ex[8] = dt & `CICR_DF_MASK;
        4'h9: ex[9] = m ? dt & 8'h09 : {ex[9][7:1], dt[0]};
        4'ha: ex[10] = dt & `CICR_PC_MASK;
        4'hc: if (m) ex[12] = dt & `CICR_MI_MASK;
        4'hd: ex[13] = dt & `CICR_DM_MASK;
        default: ;
      endcase
    end
  endtask

  task rd(input [3:0] ix);
    begin
      cw_send({4'h2, ix, 8'h00});
      if (ix == 4'hb || ix >= 4'he) chk("status", sw, rb);
      else chk("readback", {4'h2, ix, ix[3] ? ex[ix] : ard}, rb);
    end
  endtask

  task tick_gap(output integer g);
    begin
      @(posedge clk_i);
      #1;
      g = 1;
      while (tick !== 1'b1 && g < 20000) begin
        @(posedge clk_i);
        #1;
        g = g + 1;
      end
    end
  endtask

  // Crystals toggle every 2 and every 3 cycles; also the run limit.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc % 2 == 1) x1 <= ~x1;
    if (cyc % 3 == 2) x2 <= ~x2;
    if (acs === 1'b1) ncal <= ncal + 1;
    ckq <= ckp;
    if (ckp && !ckq) nck <= nck + 1;
    if (cyc == 90000) begin
      mismatches = mismatches + 1;
      give_verdict;
    end
  end

  initial begin
    ex[8] = 8'h00; ex[9] = 8'h08; ex[10] = 8'h00; ex[12] = 8'h00; ex[13] = 8'h00;
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    for (i = 8; i < 16; i = i + 1) rd(i[3:0]);
    n = ncal;
    wr(4'h9, 8'h08, 1'b1);
    wr(4'h9, 8'h09, 1'b0);
    chk("autocal", n + 1, ncal);
    wr(4'h9, 8'h00, 1'b0);
    rd(4'h9);
    wr(4'h9, 8'h00, 1'b1);
    wr(4'h9, 8'h01, 1'b0);
    chk("no_autocal", n + 1, ncal);
    rd(4'h9);
    for (k = 0; k < 32; k = k + 1) begin
      seed = rnd(seed);
      @(posedge clk_i);
      sw <= seed[31:16];
      ard <= seed[23:16];
      wr(seed[3:0], seed[15:8] | {7'h00, seed[3:0] == 4'h8}, seed[16]);
      rd(seed[3:0]);
    end
    for (i = 0; i < 3; i = i + 1) begin
      k = (i == 0) ? 5 : (i == 1) ? 6 : 3;
      wr(4'h8, {2'b01, i == 1, i == 2, k[2:0], i == 0}, 1'b1);
      chk("format", {9'h000, 1'b1, i == 1, i == 2, k[2:0], i == 0},
          {fmt, cmp, st, div, clock_source_select});
      tick_gap(n);
      tick_gap(n);
      k = nck;
      tick_gap(n);
      chk("tick_gap", (i == 0) ? 2304 : (i == 1) ? 2048 : 3072, n);
      chk("clk_out", (i == 0) ? 384 : (i == 1) ? 512 : 768, nck - k);
    end
    for (i = 0; i < 3; i = i + 1) begin
      @(posedge clk_i);
      bm <= (i != 0);
      wr(4'ha, {i[1:0], i == 2, 5'h00}, 1'b0);
      repeat (6) @(posedge clk_i);
      #1;
      chk("clk_oe", i == 1, ckoe);
      chk("xctl", i[1:0], xo);
    end
    k = 0;
    for (i = 0; i < 4; i = i + 1) begin
      wr(4'hc, {i[1:0], 6'h00}, 1'b1);
      chk("frame_pre", k[1:0], {fss, tss});
      @(posedge clk_i);
      fs <= 1'b1;
      @(posedge clk_i);
      fs <= 1'b0;
      #1;
      chk("frame", {i[1:0], i[0] ? 5'h00 : 5'h03}, {fss, tss, base});
      k = i;
    end
    for (i = 0; i < 4; i = i + 1) begin
      p = (i != 2);
      d = (i != 0);
      at = (i == 2) ? 6'd5 : (i == 3) ? 6'd63 : 6'd0;
      wr(4'h8, {3'b010, i != 3, 4'hb}, 1'b1);
      wr(4'h9, {7'h00, p}, 1'b0);
      wr(4'hd, {at, 1'b0, d}, 1'b0);
      seed = rnd(seed);
      @(posedge clk_i);
      {pv, av, und, ovr} <= {2'b11, i == 1, i == 2};
      {pl, pr} <= rnd(seed);
      {al, ar} <= ~seed;
      @(posedge clk_i);
      {pv, av} <= 2'b00;
      if (i != 2) {ea, eb} = {al, ar};
      tick_gap(n);
      repeat (2) @(posedge clk_i);
      #1;
      chk("dac_left", mixv(p && i != 1, d, at, pl, ea), dl);
      chk("dac_right", mixv(p && i != 1, d, at, i != 3 ? pr : pl, i != 3 ? eb : ea), dr);
    end
    give_verdict;
  end
endmodule // tb_top
